// ==== ded_top.sv ====
// register file and pixel walker of the drawing engine
`timescale 1ns/100ps
`default_nettype none
`include "ded_params.svh"
module ded_top (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o,
	// pixel requests to memory
	output logic mem_req_valid_o,
	output ded_pkg::ded_mem_req_t mem_req_o,
	input wire logic mem_req_ready_i,
	input wire logic mem_rd_valid_i,
	input wire logic [7:0] mem_rd_data_i,
	// status
	output logic busy_o,
	output logic irq_o
);
	import ded_pkg::*;

	// ********************************
	// declarations
	// ********************************
	ded_cmd_t cmd_q; // last command word
	logic signed [15:0] et_q, k1_q, k2_q; // line parameters
	logic [7:0] fgc_q, bgc_q; // fixed colours
	logic [11:0] dim1_q, dim2_q; // lengths minus one
	logic signed [15:0] src_x_q, src_y_q, dst_x_q, dst_y_q;
	logic [7:0] fmt_q; // map location and byte order
	logic irq_en_q, done_q, err_q;
	logic [7:0] rdbk_q; // last pixel read back
	logic [31:0] rdata_q;
	ded_st_t st_q; // engine state
	logic [11:0] cnt_q, row_q; // pixels left in row, rows left
	logic first_q; // first pixel of a line
	logic signed [15:0] cx_q, cy_q, sx_q, sy_q; // walking positions
	logic signed [15:0] bx_q, bsx_q; // row start positions
	logic signed [15:0] bres_q; // running error term
	logic valid_q;
	ded_mem_req_t req_q;
	// decode helpers
	ded_cmd_t wcmd;
	logic cmd_ok, start, fin, slot, last_px;
	logic is_line, is_step, is_blk, is_wr;
	logic signed [15:0] xs, ys, ddx, ddy, dsy;

	// ********************************
	// command decode
	// ********************************
	assign wcmd = ded_cmd_t'(reg_wdata_i);
	// every field but mode must carry a defined code before an op may start
	always_comb begin
		cmd_ok = 1'b1;
		case (wcmd.op)
			OP_STEP_RD, OP_LINE_RD, OP_STEP_WR, OP_LINE_WR: cmd_ok = 1'b1;
			OP_BLT, OP_BLT_INV, OP_BLT_FILL: cmd_ok = 1'b1;
			default: cmd_ok = 1'b0;
		endcase
		// source map must name A..C even if unused
		if (wcmd.src_map < `DED_MAP_A || wcmd.src_map > `DED_MAP_C) begin
			cmd_ok = 1'b0;
		end
		if (wcmd.dst_map < `DED_MAP_A || wcmd.dst_map > `DED_MAP_C) begin
			cmd_ok = 1'b0;
		end
		if (!((wcmd.pat_map >= `DED_MAP_A && wcmd.pat_map <= `DED_MAP_C) ||
		      wcmd.pat_map == `DED_PAT_FG || wcmd.pat_map == `DED_PAT_GEN)) begin
			cmd_ok = 1'b0;
		end
		if (wcmd.mask != `DED_MASK_OFF && wcmd.mask != `DED_MASK_BND &&
		    wcmd.mask != `DED_MASK_ON) begin
			cmd_ok = 1'b0;
		end
		if (wcmd.fg_src != `DED_SRC_COLOR && wcmd.fg_src != `DED_SRC_MAP) begin
			cmd_ok = 1'b0;
		end
		if (wcmd.bg_src != `DED_SRC_COLOR && wcmd.bg_src != `DED_SRC_MAP) begin
			cmd_ok = 1'b0;
		end
	end

	// a whole-word write of known codes to the command offset while idle starts an op
	assign start = reg_wr_i && reg_addr_i == `DED_OFS_CMD && st_q == ST_IDLE && cmd_ok;

	// running op classes
	assign is_line = cmd_q.op == OP_LINE_RD || cmd_q.op == OP_LINE_WR;
	assign is_step = cmd_q.op == OP_STEP_RD || cmd_q.op == OP_STEP_WR;
	assign is_blk = cmd_q.op[3];
	assign is_wr = cmd_q.op == OP_STEP_WR || cmd_q.op == OP_LINE_WR || is_blk;

	// octant step directions
	assign xs = cmd_q.x_negative_bit ? 16'hFFFF : 16'h0001;
	assign ys = cmd_q.y_negative_bit ? 16'hFFFF : 16'h0001;

	// line and step moves: major axis every pixel, minor on error sign for lines only
	always_comb begin
		ddx = 16'h0000;
		ddy = 16'h0000;
		if (cmd_q.y_major_bit) begin
			ddy = ys;
			if (is_line && !bres_q[15]) begin
				ddx = xs;
			end
		end else begin
			ddx = xs;
			if (is_line && !bres_q[15]) begin
				ddy = ys;
			end
		end
	end

	// the inverted copy walks the source the other way up
	assign dsy = (cmd_q.op == OP_BLT_INV) ? -ys : ys;

	// a new pixel may be prepared when the output slot is free
	assign slot = st_q == ST_RUN && (!valid_q || mem_req_ready_i);
	assign last_px = cnt_q == 12'h000 && (!is_blk || row_q == 12'h000);
	assign fin = st_q == ST_FIN;

	// ********************************
	// engine state
	// ********************************
	// run until the final pixel has left the slot, then report once
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q <= ST_IDLE;
		end else begin
			case (st_q)
				ST_IDLE: begin
					if (start) begin
						st_q <= ST_RUN;
					end
				end
				ST_RUN: begin
					if (slot && last_px) begin
						st_q <= ST_FIN;
					end
				end
				ST_FIN: begin
					if (!valid_q || mem_req_ready_i) begin
						st_q <= ST_IDLE;
					end
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end

	// ********************************
	// pixel walker
	// ********************************
	// positions load from the programmed registers on start
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cnt_q <= 12'h000;
			row_q <= 12'h000;
			first_q <= 1'b0;
			cx_q <= `DED_RST_WORD;
			cy_q <= `DED_RST_WORD;
			sx_q <= `DED_RST_WORD;
			sy_q <= `DED_RST_WORD;
			bx_q <= `DED_RST_WORD;
			bsx_q <= `DED_RST_WORD;
			bres_q <= `DED_RST_WORD;
		end else if (start) begin
			cnt_q <= dim1_q;
			row_q <= dim2_q;
			first_q <= 1'b1;
			cx_q <= dst_x_q;
			cy_q <= dst_y_q;
			bx_q <= dst_x_q;
			sx_q <= src_x_q;
			bsx_q <= src_x_q;
			bres_q <= et_q;
			// inverted copy reads the far end first
			if (wcmd.op == OP_BLT_INV) begin
				sy_q <= wcmd.y_negative_bit ? src_y_q - {4'h0, dim2_q} : src_y_q + {4'h0, dim2_q};
			end else begin
				sy_q <= src_y_q;
			end
		end else if (slot && !last_px) begin
			first_q <= 1'b0;
			if (is_blk) begin
				// rectangle walk row by row along x, directions from the sign bits
				if (cnt_q != 12'h000) begin
					cnt_q <= cnt_q - 12'h001;
					cx_q <= cx_q + xs;
					sx_q <= sx_q + xs;
				end else begin
					cnt_q <= dim1_q;
					row_q <= row_q - 12'h001;
					cx_q <= bx_q;
					sx_q <= bsx_q;
					cy_q <= cy_q + ys;
					sy_q <= sy_q + dsy;
				end
			end else begin
				// line or draw-and-step move
				cnt_q <= cnt_q - 12'h001;
				cx_q <= cx_q + ddx;
				cy_q <= cy_q + ddy;
				sx_q <= sx_q + ddx;
				sy_q <= sy_q + ddy;
				if (is_line) begin
					bres_q <= bres_q + (bres_q[15] ? k1_q : k2_q);
				end
			end
		end
	end

	// ********************************
	// request output
	// ********************************
	// null pixels of a line advance the walk but issue nothing
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			valid_q <= 1'b0;
			req_q <= '0;
		end else if (slot) begin
			valid_q <= 1'b1;
			if ((is_line || is_step) && cmd_q.mode == `DED_MODE_FIRST_NULL && first_q) begin
				valid_q <= 1'b0;
			end
			if (is_line && cmd_q.mode == `DED_MODE_LAST_NULL && cnt_q == 12'h000) begin
				valid_q <= 1'b0;
			end
			req_q.write <= is_wr;
			req_q.boundary <= is_line && cmd_q.mode == `DED_MODE_LAST_NULL;
			req_q.fill <= cmd_q.op == OP_BLT_FILL;
			req_q.src_map <= cmd_q.src_map[1:0];
			req_q.dst_map <= cmd_q.dst_map[1:0];
			req_q.pat_map <= cmd_q.pat_map;
			req_q.mask <= cmd_q.mask;
			req_q.fg_from_src <= cmd_q.fg_src == `DED_SRC_MAP;
			req_q.bg_from_src <= cmd_q.bg_src == `DED_SRC_MAP;
			// swap only for maps held in system memory
			req_q.src_swap <= fmt_q[`DED_FMT_SYS_LSB + cmd_q.src_map[1:0] - 1] &&
			                  fmt_q[`DED_FMT_BE_LSB + cmd_q.src_map[1:0] - 1];
			req_q.dst_swap <= fmt_q[`DED_FMT_SYS_LSB + cmd_q.dst_map[1:0] - 1] &&
			                  fmt_q[`DED_FMT_BE_LSB + cmd_q.dst_map[1:0] - 1];
			req_q.fg_color <= fgc_q;
			req_q.bg_color <= bgc_q;
			req_q.src_x <= sx_q;
			req_q.src_y <= sy_q;
			req_q.dst_x <= cx_q;
			req_q.dst_y <= cy_q;
		end else if (mem_req_ready_i) begin
			valid_q <= 1'b0;
		end
	end

	// ********************************
	// register file
	// ********************************
	// writes are taken only while idle, so a running op keeps its view
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_q <= ded_cmd_t'(`DED_RST_CMD);
			et_q <= `DED_RST_WORD;
			k1_q <= `DED_RST_WORD;
			k2_q <= `DED_RST_WORD;
			fgc_q <= 8'h00;
			bgc_q <= 8'h00;
			dim1_q <= 12'h000;
			dim2_q <= 12'h000;
			src_x_q <= `DED_RST_WORD;
			src_y_q <= `DED_RST_WORD;
			dst_x_q <= `DED_RST_WORD;
			dst_y_q <= `DED_RST_WORD;
			fmt_q <= 8'h00;
			irq_en_q <= 1'b0;
		end else if (fin) begin
			// keep the end point so a line goes on by a new length
			if (is_line || is_step) begin
				dst_x_q <= cx_q;
				dst_y_q <= cy_q;
				et_q <= bres_q;
			end
		end else if (reg_wr_i && st_q == ST_IDLE) begin
			if (reg_addr_i == `DED_OFS_CTRL) begin
				irq_en_q <= reg_wdata_i[`DED_CTRL_IRQEN];
			end else if (reg_addr_i == `DED_OFS_FMT) begin
				fmt_q <= {1'b0, reg_wdata_i[6:4], 1'b0, reg_wdata_i[2:0]};
			end else if (reg_addr_i == `DED_OFS_ET) begin
				et_q <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `DED_OFS_K1) begin
				k1_q <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `DED_OFS_K2) begin
				k2_q <= reg_wdata_i[15:0];
			end else if (reg_addr_i == `DED_OFS_FGC) begin
				fgc_q <= reg_wdata_i[7:0];
			end else if (reg_addr_i == `DED_OFS_BGC) begin
				bgc_q <= reg_wdata_i[7:0];
			end else if (reg_addr_i == `DED_OFS_DIM1) begin
				dim1_q <= reg_wdata_i[11:0];
			end else if (reg_addr_i == `DED_OFS_DIM2) begin
				dim2_q <= reg_wdata_i[11:0];
			end else if (reg_addr_i == `DED_OFS_SRCXY) begin
				src_x_q <= reg_wdata_i[15:0];
				src_y_q <= reg_wdata_i[31:16];
			end else if (reg_addr_i == `DED_OFS_DSTXY) begin
				dst_x_q <= reg_wdata_i[15:0];
				dst_y_q <= reg_wdata_i[31:16];
			end else if (start) begin
				cmd_q <= wcmd;
			end
		end
	end

	// sticky flags: a set in the clearing cycle wins
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			done_q <= 1'b0;
			err_q <= 1'b0;
		end else begin
			if (fin && (!valid_q || mem_req_ready_i)) begin
				done_q <= 1'b1;
			end else if (reg_wr_i && reg_addr_i == `DED_OFS_CTRL && reg_wdata_i[`DED_CTRL_DONE]) begin
				done_q <= 1'b0;
			end
			// bad codes or a command while busy are refused and flagged
			if (reg_wr_i && reg_addr_i == `DED_OFS_CMD && !start) begin
				err_q <= 1'b1;
			end else if (reg_wr_i && reg_addr_i == `DED_OFS_CTRL && reg_wdata_i[`DED_CTRL_ERR]) begin
				err_q <= 1'b0;
			end
		end
	end

	// last pixel returned by a read operation
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdbk_q <= 8'h00;
		end else if (mem_rd_valid_i) begin
			rdbk_q <= mem_rd_data_i;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (!reg_rd_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (reg_addr_i == `DED_OFS_CTRL) begin
			rdata_q <= {28'h0, err_q, done_q, irq_en_q, st_q != ST_IDLE};
		end else if (reg_addr_i == `DED_OFS_FMT) begin
			rdata_q <= {24'h0, fmt_q};
		end else if (reg_addr_i == `DED_OFS_RDBK) begin
			rdata_q <= {24'h0, rdbk_q};
		end else if (reg_addr_i == `DED_OFS_ET) begin
			rdata_q <= {16'h0, et_q};
		end else if (reg_addr_i == `DED_OFS_K1) begin
			rdata_q <= {16'h0, k1_q};
		end else if (reg_addr_i == `DED_OFS_K2) begin
			rdata_q <= {16'h0, k2_q};
		end else if (reg_addr_i == `DED_OFS_FGC) begin
			rdata_q <= {24'h0, fgc_q};
		end else if (reg_addr_i == `DED_OFS_BGC) begin
			rdata_q <= {24'h0, bgc_q};
		end else if (reg_addr_i == `DED_OFS_DIM1) begin
			rdata_q <= {20'h0, dim1_q};
		end else if (reg_addr_i == `DED_OFS_DIM2) begin
			rdata_q <= {20'h0, dim2_q};
		end else if (reg_addr_i == `DED_OFS_SRCXY) begin
			rdata_q <= {src_y_q, src_x_q};
		end else if (reg_addr_i == `DED_OFS_DSTXY) begin
			rdata_q <= {dst_y_q, dst_x_q};
		end else if (reg_addr_i == `DED_OFS_CMD) begin
			rdata_q <= cmd_q;
		end else begin
			rdata_q <= 32'h0000_0000; // unmapped reads as zero
		end
	end

	// ********************************
	// outputs
	// ********************************
	assign reg_rdata_o = rdata_q;
	assign mem_req_valid_o = valid_q;
	assign mem_req_o = req_q;
	assign busy_o = st_q != ST_IDLE;
	assign irq_o = irq_en_q && done_q;
endmodule // ded_top
`default_nettype wire

// ==== ded_params.svh ====
// constants for the drawing engine operation decoder
`ifndef DED_PARAMS_SVH
`define DED_PARAMS_SVH
// register byte offsets
`define DED_OFS_CTRL 8'h00
`define DED_OFS_FMT 8'h04
`define DED_OFS_RDBK 8'h08
`define DED_OFS_ET 8'h20
`define DED_OFS_K1 8'h24
`define DED_OFS_K2 8'h28
`define DED_OFS_FGC 8'h58
`define DED_OFS_BGC 8'h5C
`define DED_OFS_DIM1 8'h60
`define DED_OFS_DIM2 8'h64
`define DED_OFS_SRCXY 8'h70
`define DED_OFS_DSTXY 8'h78
`define DED_OFS_CMD 8'h7C
// control register bit positions
`define DED_CTRL_BUSY 0
`define DED_CTRL_IRQEN 1
`define DED_CTRL_DONE 2
`define DED_CTRL_ERR 3
// format register: bits 2:0 map in system memory, bits 6:4 swapped order
`define DED_FMT_SYS_LSB 0
`define DED_FMT_BE_LSB 4
// field codes
`define DED_SRC_COLOR 2'b00
`define DED_SRC_MAP 2'b10
`define DED_MAP_A 4'h1
`define DED_MAP_C 4'h3
`define DED_PAT_FG 4'h8
`define DED_PAT_GEN 4'h9
`define DED_MASK_OFF 2'b00
`define DED_MASK_BND 2'b01
`define DED_MASK_ON 2'b10
`define DED_MODE_ALL 2'b00
`define DED_MODE_FIRST_NULL 2'b01
`define DED_MODE_LAST_NULL 2'b11
// reset values
`define DED_RST_CMD 32'h0000_0000
`define DED_RST_WORD 16'h0000
`endif

// ==== ded_pkg.sv ====
// types shared by the drawing engine operation decoder
package ded_pkg;
	// operation type codes
	typedef enum logic [3:0] {
		OP_STEP_RD = 4'b0010,
		OP_LINE_RD = 4'b0011,
		OP_STEP_WR = 4'b0100,
		OP_LINE_WR = 4'b0101,
		OP_BLT = 4'b1000,
		OP_BLT_INV = 4'b1001,
		OP_BLT_FILL = 4'b1010
	} ded_op_t;
	// engine states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN = 2'b01,
		ST_FIN = 2'b10
	} ded_st_t;
	// operation command word layout, msb first
	typedef struct packed {
		logic [1:0] bg_src;
		logic [1:0] fg_src;
		logic [3:0] op;
		logic [3:0] src_map;
		logic [3:0] dst_map;
		logic [3:0] pat_map;
		logic [3:0] rsv_hi;
		logic [1:0] mask;
		logic [1:0] mode;
		logic rsv_lo;
		logic x_negative_bit;
		logic y_negative_bit;
		logic y_major_bit;
	} ded_cmd_t;
	// one pixel request towards memory
	typedef struct packed {
		logic write;
		logic boundary;
		logic fill;
		logic [1:0] src_map;
		logic [1:0] dst_map;
		logic [3:0] pat_map;
		logic [1:0] mask;
		logic fg_from_src;
		logic bg_from_src;
		logic src_swap;
		logic dst_swap;
		logic [7:0] fg_color;
		logic [7:0] bg_color;
		logic signed [15:0] src_x;
		logic signed [15:0] src_y;
		logic signed [15:0] dst_x;
		logic signed [15:0] dst_y;
	} ded_mem_req_t;
endpackage

// ==== ded_note_end.sv ====
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// ==== ded_top_assertions.sv ====
// port checks for the drawing engine decoder
`timescale 1ns/100ps
`default_nettype none
module ded_top_assertions (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [31:0] reg_rdata_o,
	// memory side and status
	input wire logic mem_req_valid_o,
	input wire ded_pkg::ded_mem_req_t mem_req_o,
	input wire logic mem_req_ready_i,
	input wire logic busy_o,
	input wire logic irq_o
);
	import ded_pkg::*;
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_b_i);
	logic [31:0] w; // word on the write bus
	logic cmd_wr; // write to the command word
	logic cmd_ok; // every field but mode holds a known code
	assign w = reg_wdata_i;
	assign cmd_wr = reg_wr_i && reg_addr_i == 8'h7C;
	assign cmd_ok = w[27:24] inside {4'h2, 4'h3, 4'h4, 4'h5, 4'h8, 4'h9, 4'hA}
		&& w[23:20] inside {4'h1, 4'h2, 4'h3} && w[19:16] inside {4'h1, 4'h2, 4'h3}
		&& w[15:12] inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9} && w[7:6] != 2'h3
		&& !w[28] && !w[30];
	// clean start: idle, known codes, no pixel nulled
	sequence s_go;
		cmd_wr && !busy_o && cmd_ok && w[5:4] == 2'h0;
	endsequence
	// busy first, then the first pixel request
	sequence s_run;
		busy_o ##1 mem_req_valid_o;
	endsequence
	start_req_a: assert property (s_go |=> s_run)
		else $error("command did not start the walk");
	bad_code_a: assert property (cmd_wr && !busy_o && !cmd_ok |=> !busy_o)
		else $error("unknown code started an operation");
	busy_cause_a: assert property ($rose(busy_o) |-> $past(cmd_wr))
		else $error("busy rose without a command write");
	busy_read_a: assert property (reg_rd_i && reg_addr_i == 8'h00 |=>
		reg_rdata_o[0] == $past(busy_o))
		else $error("busy bit read wrong");
	rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
		else $error("read data outside the answer cycle");
	req_hold_a: assert property (mem_req_valid_o && !mem_req_ready_i |=>
		mem_req_valid_o && $stable(mem_req_o))
		else $error("pixel request dropped or changed");
	req_busy_a: assert property (mem_req_valid_o |-> busy_o)
		else $error("pixel request while idle");
	// the last request may be taken in the very cycle that ends the op
	finish_a: assert property ($fell(busy_o) |-> !mem_req_valid_o &&
		(!$past(mem_req_valid_o) || $past(mem_req_ready_i)))
		else $error("busy fell with a request open");
	irq_idle_a: assert property ($rose(irq_o) |-> !busy_o)
		else $error("interrupt before completion");
endmodule // ded_top_assertions
bind ded_top ded_top_assertions u_chk (.mclk_i(mclk_i), .rst_b_i(rst_b_i),
	.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
	.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mem_req_valid_o(mem_req_valid_o),
	.mem_req_o(mem_req_o), .mem_req_ready_i(mem_req_ready_i), .busy_o(busy_o),
	.irq_o(irq_o));
`default_nettype wire

// ==== ded_mem_model.sv ====
// memory-side partner answering pixel requests
`timescale 1ns/100ps
`default_nettype none
module ded_mem_model #(
	parameter logic [7:0] RD_DATA = 8'hC3 // pixel value returned on reads
) (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// request side
	input wire logic slow_i,
	input wire logic req_valid_i,
	input wire logic req_write_i,
	output logic ready_o,
	// read return
	output logic rd_valid_o,
	output logic [7:0] rd_data_o
);
	logic [1:0] pend_q; // read answers in flight
	// acceptance; random stalls when slow to exercise back-pressure
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) ready_o <= 1'b0;
		else ready_o <= !slow_i || ($urandom % 3 == 0);
	end
	// reads answered three cycles after acceptance; idle data keep moving so stale values never match
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			pend_q <= 2'h0;
			rd_valid_o <= 1'b0;
			rd_data_o <= 8'h00;
		end else begin
			pend_q <= {pend_q[0], req_valid_i && ready_o && !req_write_i};
			rd_valid_o <= pend_q[1];
			rd_data_o <= pend_q[1] ? RD_DATA : rd_data_o + 8'h5B;
		end
	end
endmodule // ded_mem_model
`default_nettype wire

// ==== tb_ded_top.sv ====
// self-checking bench of the drawing engine decoder
`timescale 1ns/100ps
`default_nettype none
module tb_ded_top;
	import ded_pkg::*;
	// expected pixel: flags, compare-source flag, dst x y, src x y
	typedef struct packed {logic [32:0] f; logic s; logic [63:0] p;} ded_px_t;
	logic mclk_i, rst_b_i, reg_wr_i, reg_rd_i, rdy, rdv, vld, busy_o, irq_o, slow, rd_seen;
	logic [7:0] reg_addr_i, rdd;
	logic [31:0] reg_wdata_i, reg_rdata_o, c;
	ded_mem_req_t req;
	logic [31:0] q_rd[$]; // expected read data
	ded_px_t q_px[$]; // expected pixel requests
	int n_mismatch, n_checks, i;
	ded_top dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_rdata_o(reg_rdata_o), .mem_req_valid_o(vld), .mem_req_o(req),
		.mem_req_ready_i(rdy), .mem_rd_valid_i(rdv), .mem_rd_data_i(rdd),
		.busy_o(busy_o), .irq_o(irq_o));
	ded_mem_model mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .slow_i(slow),
		.req_valid_i(vld), .req_write_i(req.write), .ready_o(rdy), .rd_valid_o(rdv),
		.rd_data_o(rdd));
	// ****************
	// checking helpers
	// ****************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic fail(input string m);
		$display("BAD %0t %s", $time, m);
		n_mismatch++;
	endtask
	task automatic cmp_rd(input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) fail("register read");
	endtask
	task automatic cmp_bit(input logic e, input logic g);
		n_checks++;
		if (g !== e) fail("status flag");
	endtask
	task automatic cmp_px(input ded_px_t e);
		ded_px_t g;
		g = {req.boundary, req.write, req.fill, req.dst_swap, req.src_swap, req.fg_from_src,
			req.bg_from_src, req.src_map, req.dst_map, req.mask, req.pat_map, req.fg_color,
			req.bg_color, e.s, req.dst_x, req.dst_y, req.src_x, req.src_y};
		if (!e.s) g.p[31:0] = e.p[31:0];
		n_checks++;
		if (g !== e) fail("pixel request");
	endtask
	// result watcher: read answers one cycle after the strobe, pixels on acceptance
	always @(posedge mclk_i) begin
		if (rd_seen && q_rd.size() > 0) cmp_rd(q_rd.pop_front(), reg_rdata_o);
		rd_seen <= reg_rd_i;
		if (vld && rdy) begin
			if (q_px.size() > 0) cmp_px(q_px.pop_front());
			else fail("extra pixel");
		end
	end
	// random command word; map codes always valid
	function automatic logic [31:0] mk(input logic [3:0] op, pat, input logic [1:0] mk_m,
		input logic [1:0] mode, input logic [2:0] oct);
		logic [3:0] s, d;
		s = 4'h1 + 4'($urandom % 3);
		d = 4'h1 + 4'($urandom % 3);
		return {1'($urandom % 2), 1'b0, 1'($urandom % 2), 1'b0, op, s, d, pat, 4'h0, mk_m,
			mode, 1'b0, oct};
	endfunction
	function automatic ded_px_t mkpx(input logic [31:0] c, input logic s,
		input int dx, dy, sx, sy);
		logic [3:0] op;
		op = c[27:24];
		// only map A sits in system memory with swapped order; B is swapped but in video
		return {c[5:4] == 2'h3 && (op == 4'h3 || op == 4'h5), !(op == 4'h2 || op == 4'h3),
			op == 4'hA, c[19:16] == 4'h1, c[23:20] == 4'h1, c[29], c[31], c[21:20], c[17:16],
			c[7:6], c[15:12], 8'h5A, 8'hA5, s, 16'(dx), 16'(dy), 16'(sx), 16'(sy)};
	endfunction
	task automatic exp_line(input logic [31:0] c, input int n, x, y, e, k1, k2);
		int xs, ys;
		xs = c[2] ? -1 : 1;
		ys = c[1] ? -1 : 1;
		for (int j = 0; j < n; j++) begin
			if (!(c[5:4] == 2'h1 && j == 0) && !(c[5:4] == 2'h3 && c[24] && j == n - 1))
				q_px.push_back(mkpx(c, 1'b0, x, y, 0, 0));
			if (c[0]) y = y + ys;
			else x = x + xs;
			if (c[24] && e >= 0) begin
				if (c[0]) x = x + xs;
				else y = y + ys;
				e = e + k2;
			end else if (c[24]) e = e + k1;
		end
	endtask
	task automatic exp_blk(input logic [31:0] c, input int d1, d2, dx, dy, sx, sy);
		int xs, ys;
		xs = c[2] ? -1 : 1;
		ys = c[1] ? -1 : 1;
		for (int r = 0; r <= d2; r++)
			for (int q = 0; q <= d1; q++)
				q_px.push_back(mkpx(c, 1'b1, dx + q * xs, dy + r * ys, sx + q * xs,
					c[24] ? sy + (d2 - r) * ys : sy + r * ys));
	endtask
	// ****************
	// register bus
	// ****************
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge mclk_i);
		reg_wr_i <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		q_rd.push_back(e);
		@(posedge mclk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge mclk_i);
		reg_rd_i <= 1'b0;
	endtask
	// bounded wait for the engine to go idle, then all pixels must be seen
	task automatic wait_idle();
		int k;
		repeat (3) @(posedge mclk_i);
		for (k = 0; k < 3000 && busy_o !== 1'b0; k++) @(posedge mclk_i);
		if (k == 3000) begin
			fail("timeout");
			report_and_stop();
		end
		cmp_rd(32'h0, q_px.size());
	endtask
	initial begin
		mclk_i = 1'b0;
		forever #10 mclk_i = ~mclk_i;
	end
	// main sequence
	initial begin
		{rst_b_i, reg_wr_i, reg_rd_i, slow} = 4'h0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 32'h0;
		n_mismatch = 0;
		n_checks = 0;
		i = $urandom(92);
		repeat (3) @(posedge mclk_i);
		rst_b_i <= 1'b1;
		rreg(8'h00, 32'h0);
		rreg(8'h7C, 32'h0);
		rreg(8'h10, 32'h0);
		wreg(8'h60, 32'h1FFF);
		rreg(8'h60, 32'hFFF);
		wreg(8'h04, 32'h31); // map A in system memory and swapped, B swapped only
		wreg(8'h00, 32'hE);
		wreg(8'h24, 32'h4);
		wreg(8'h28, 32'hFFFC);
		wreg(8'h58, 32'h5A);
		wreg(8'h5C, 32'hA5);
		wreg(8'h60, 32'h3);
		// line ops in the odd (y-major) octants, step ops in the even ones, each drawing mode
		for (int o = 0; o < 8; o++) begin
			c = mk(4'h2 + 4'(o % 4), o % 5 < 3 ? 4'(o % 5 + 1) : 4'(o % 5 + 5), 2'(o % 3),
				o % 4 == 2 ? 2'h3 : 2'(o % 4), 3'(o));
			wreg(8'h78, 32'h0028_0032);
			wreg(8'h20, 32'h0);
			exp_line(c, 4, 50, 40, 0, 4, -4);
			slow <= 1'(o % 2);
			wreg(8'h7C, c);
			wait_idle();
		end
		// last line ends on its final pixel, nulled in this mode, error term kept for a continuation
		rreg(8'h78, 32'h0025_0030);
		rreg(8'h20, 32'h0000_FFFC);
		rreg(8'h08, 32'hC3);
		rreg(8'h00, 32'h6);
		cmp_bit(1'b1, irq_o);
		wreg(8'h70, 32'h0005_0006);
		wreg(8'h64, 32'h2);
		wreg(8'h60, 32'h1);
		// the three block transfers; the last also gets a command while busy
		for (int b = 0; b < 3; b++) begin
			c = mk(4'h8 + 4'(b), 4'h9, 2'h0, 2'h0, b == 0 ? 3'h4 : 3'(b - 1) << 1);
			wreg(8'h78, 32'h0014_001E);
			exp_blk(c, 1, 2, 30, 20, 6, 5);
			slow <= 1'b1;
			wreg(8'h7C, c);
			if (b == 2) wreg(8'h7C, c);
			wait_idle();
		end
		rreg(8'h00, 32'hE);
		rreg(8'h7C, c);
		wreg(8'h00, 32'h0);
		repeat (2) @(posedge mclk_i);
		cmp_bit(1'b0, irq_o);
		rreg(8'h00, 32'hC);
		wreg(8'h00, 32'hE);
		// commands with one unknown field each are refused
		for (int k = 0; k < 6; k++) begin
			c = mk(4'h8, 4'h8, 2'h0, 2'h0, 3'h0);
			case (k)
				0: c[27:24] = 4'h0;
				1: c[23:20] = 4'h0;
				2: c[19:16] = 4'h4;
				3: c[15:12] = 4'h4;
				4: c[7:6] = 2'h3;
				default: c[29:28] = 2'h1;
			endcase
			wreg(8'h7C, c);
			rreg(8'h00, 32'hA);
			wreg(8'h00, 32'hE);
		end
		repeat (3) @(posedge mclk_i);
		report_and_stop();
	end
endmodule // tb_ded_top
`default_nettype wire
